// ==== common/hcc_link_if.sv ====
// Register access link between the host-side driver and the control bank.
// Assumes both ends share i_sys_clk; the testbench instantiates and joins them.
`timescale 1ns/10ps
interface hcc_link_if;
  logic req;
  logic we;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  logic abort;
  logic bus_reset_req;
  modport dev (input req, input we, input addr, input wdata, input bus_reset_req,
    output rdata, output ack, output abort);
  modport host (output req, output we, output addr, output wdata, output bus_reset_req,
    input rdata, input ack, input abort);
endinterface

// ==== common/hcc_pkg.sv ====
// Shared constants for the host controller control bank and its host-side driver.
// Assumes a single 20 MHz system clock shared by both ends.
package hcc_pkg;
  localparam int HCC_CLK_MHZ = 20;
  localparam int HCC_AW = 12;
  // Control register views and the miscellaneous configuration register
  localparam logic [11:0] HCC_OFF_SET = 12'h050;
  localparam logic [11:0] HCC_OFF_CLR = 12'h054;
  localparam logic [11:0] HCC_OFF_MISC = 12'h0f0;
  // Ranges served by logic that runs from the physical layer clock
  localparam logic [11:0] HCC_PHY_LO1 = 12'h0dc;
  localparam logic [11:0] HCC_PHY_HI1 = 12'h0f0;
  localparam logic [11:0] HCC_PHY_LO2 = 12'h100;
  localparam logic [11:0] HCC_PHY_HI2 = 12'h11c;
  // Control field positions
  localparam int HCC_B_SWAP = 30;
  localparam int HCC_B_PERMIT = 23;
  localparam int HCC_B_ENH = 22;
  localparam int HCC_B_LPS = 19;
  localparam int HCC_B_PW = 18;
  localparam int HCC_B_LINK = 17;
  localparam int HCC_B_SRST = 16;
  localparam int HCC_B_ABT_SUP = 4;
  // Values after hardware reset; self reset restores all but permit and abort suppress
  localparam logic HCC_SWAP_RST = 1'b0;
  localparam logic HCC_ENH_RST = 1'b0;
  localparam logic HCC_LPS_RST = 1'b0;
  localparam logic HCC_PW_RST = 1'b0;
  localparam logic HCC_LINK_RST = 1'b0;
  localparam logic HCC_PERMIT_RST = 1'b0;
  localparam logic HCC_ABT_SUP_RST = 1'b0;
  localparam logic [31:0] HCC_STOPPED_DATA = 32'hffff_ffff;
  // Self reset duration in cycles
  localparam int HCC_SR_CYCLES = 8;
  // Clock settle wait after raising link power status
  localparam int HCC_SETTLE_MS = 10;
  localparam int HCC_SETTLE_CYC = HCC_SETTLE_MS * HCC_CLK_MHZ * 1000;
  // Host-side command registers on the AXI4-Lite port
  localparam logic [7:0] HCC_H_ADDR = 8'h00;
  localparam logic [7:0] HCC_H_WDATA = 8'h04;
  localparam logic [7:0] HCC_H_GO = 8'h08;
  localparam logic [7:0] HCC_H_STATUS = 8'h0c;
  localparam logic [7:0] HCC_H_RDATA = 8'h10;
  localparam logic [7:0] HCC_H_SHADOW = 8'h14;
  localparam int HCC_GO_WE = 0;
  localparam int HCC_GO_START = 1;
  localparam int HCC_GO_BUSRST = 2;
endpackage

// ==== core/hcc_device_end.sv ====
// Host controller control bank: set/clear control register, miscellaneous
// abort suppress bit and the stopped-clock answer for physical layer registers.
// Assumes the host holds req until it sees ack or abort, then drops it.
//
// Operation
// - Set view sets, clear view clears bits
// - Reserved control bits always read zero
// - Bit 30 selects data byte swapping
// - Permit bit loaded from ROM, host clears only
// - Driver touches enhancements only when permitted
// - Enhancements on needs permit and link
// - Link power status gates link-PHY traffic
// - Stopped PHY clock access gets abort
// - Abort suppress completes with all ones
// - DCh-F0h and 100h-11Ch are PHY-clocked
// - Host waits 10 ms after raising power
// - Bit 18 enables posted writes
// - Posted-write bit changed only while detached
// - Link enable cleared by both resets
// - Driver sets link enable then bus reset
// - Link enable low detaches from bus
// - Self reset restores register defaults except permit and abort suppress
// - Self reset bit reads one until done
`timescale 1ns/10ps
module hcc_device_end
  import hcc_pkg::*;
#(
  parameter int SR_CYCLES = HCC_SR_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  hcc_link_if.dev lnk,
  input wire logic i_phy_clk_live,
  input wire logic i_rom_load,
  input wire logic i_rom_permit,
  output logic o_data_swap_disable,
  output logic o_enhancement_features_on,
  output logic o_phy_comm_enable,
  output logic o_posted_write_on,
  output logic o_bus_attached,
  output logic o_flush,
  output logic o_bus_reset
);
  localparam int SRW = $clog2(SR_CYCLES + 1);

  // Whole device state: control bits, link answer, PHY-side staging and pulses
  typedef struct packed {
    // Control bits as software reads them
    logic swap_dis;
    logic permit;
    logic enh_on;
    logic link_power_status;
    logic pw_on;
    logic link_en;
    logic abt_sup;
    logic [SRW-1:0] sr_cnt;
    // Link answer; rdata holds until the next answer
    logic ack;
    logic abort;
    logic [31:0] rdata;
    // Staging and pulses toward the PHY side
    logic [4:0] stg1;
    logic [4:0] stg2;
    logic flush;
    logic bus_rst;
  } hcc_dev_s;

  hcc_dev_s s_r;
  hcc_dev_s s_nxt;

  // True for offsets whose registers run from the physical layer clock
  function automatic logic in_phy_dom(input logic [11:0] a);
    in_phy_dom = ((a >= HCC_PHY_LO1) && (a <= HCC_PHY_HI1)) ||
      ((a >= HCC_PHY_LO2) && (a <= HCC_PHY_HI2));
  endfunction

  // Control word as read through either view
  function automatic logic [31:0] ctl_word(input hcc_dev_s s);
    ctl_word = '0;
    ctl_word[HCC_B_SWAP] = s.swap_dis;
    ctl_word[HCC_B_PERMIT] = s.permit;
    ctl_word[HCC_B_ENH] = s.enh_on;
    ctl_word[HCC_B_LPS] = s.link_power_status;
    ctl_word[HCC_B_PW] = s.pw_on;
    ctl_word[HCC_B_LINK] = s.link_en;
    ctl_word[HCC_B_SRST] = (s.sr_cnt != '0);
  endfunction

  // Either view of the control word; both read back the same value
  function automatic logic ctl_view(input logic [11:0] a);
    ctl_view = (a == HCC_OFF_SET) || (a == HCC_OFF_CLR);
  endfunction

  // Next state: host access, self reset, ROM load, PHY-side staging
  always_comb begin
    logic take;
    logic [31:0] w;
    take = lnk.req && !s_r.ack && !s_r.abort;
    w = lnk.wdata;
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.abort = 1'b0;
    // A request is taken only while no answer is out, so a req still held
    // in the answer cycle is not served twice
    if (take) begin
      if (in_phy_dom(lnk.addr) && !i_phy_clk_live) begin
        // The stopped domain cannot answer; writes are dropped either way
        if (s_r.abt_sup) begin
          s_nxt.ack = 1'b1;
          s_nxt.rdata = HCC_STOPPED_DATA;
        end else begin
          s_nxt.abort = 1'b1;
        end
      end else begin
        s_nxt.ack = 1'b1;
        // Read data comes from the old state, so a write shows on the next read
        if (ctl_view(lnk.addr)) begin
          s_nxt.rdata = ctl_word(s_r);
        end else if (lnk.addr == HCC_OFF_MISC) begin
          s_nxt.rdata = {27'h0000000, s_r.abt_sup, 4'h0};
        end else begin
          // Unmapped offsets read zero; writes to them are dropped
          s_nxt.rdata = '0;
        end
        if (lnk.we && lnk.addr == HCC_OFF_SET) begin
          // Permit bit has no set path; only the ROM raises it
          s_nxt.swap_dis = s_r.swap_dis | w[HCC_B_SWAP];
          s_nxt.enh_on = s_r.enh_on | w[HCC_B_ENH];
          s_nxt.link_power_status = s_r.link_power_status | w[HCC_B_LPS];
          s_nxt.pw_on = s_r.pw_on | w[HCC_B_PW];
          s_nxt.link_en = s_r.link_en | w[HCC_B_LINK];
          if (w[HCC_B_SRST] && s_r.sr_cnt == '0) begin
            s_nxt.sr_cnt = SRW'(SR_CYCLES);
          end
        end else if (lnk.we && lnk.addr == HCC_OFF_CLR) begin
          s_nxt.swap_dis = s_r.swap_dis & ~w[HCC_B_SWAP];
          s_nxt.permit = s_r.permit & ~w[HCC_B_PERMIT];
          s_nxt.enh_on = s_r.enh_on & ~w[HCC_B_ENH];
          s_nxt.link_power_status = s_r.link_power_status & ~w[HCC_B_LPS];
          s_nxt.pw_on = s_r.pw_on & ~w[HCC_B_PW];
          s_nxt.link_en = s_r.link_en & ~w[HCC_B_LINK];
        end else if (lnk.we && lnk.addr == HCC_OFF_MISC) begin
          s_nxt.abt_sup = w[HCC_B_ABT_SUP];
        end
      end
    end

    // Self reset holds control fields at defaults for its whole span
    // A host set in that span is lost; the permit and abort suppress are kept
    if (s_r.sr_cnt != '0) begin
      s_nxt.sr_cnt = s_r.sr_cnt - SRW'(1);
      s_nxt.swap_dis = HCC_SWAP_RST;
      s_nxt.enh_on = HCC_ENH_RST;
      s_nxt.link_power_status = HCC_LPS_RST;
      s_nxt.pw_on = HCC_PW_RST;
      s_nxt.link_en = HCC_LINK_RST;
    end
    // ROM load wins over a host clear in the same cycle
    if (i_rom_load) begin
      s_nxt.permit = i_rom_permit;
    end
    s_nxt.flush = (s_nxt.sr_cnt != '0);

    // Two-stage staging so PHY-side logic sees each change cleanly
    // With one clock the PHY domain is only modelled, but the outputs keep
    // the latency that a real crossing would add
    s_nxt.stg1 = {s_r.swap_dis, s_r.enh_on, s_r.link_power_status, s_r.pw_on, s_r.link_en};
    s_nxt.stg2 = s_r.stg1;
    // Bus reset forwarded only while attached and powered. The request and
    // the gate are both on the host clock: a gate taken from the staged copy
    // would drop the reset that follows at once on setting link enable
    s_nxt.bus_rst = lnk.bus_reset_req && s_r.link_en && s_r.link_power_status;
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      // Answer and staging flops clear; control bits take their reset values
      s_r <= '0;
      s_r.swap_dis <= HCC_SWAP_RST;
      s_r.permit <= HCC_PERMIT_RST;
      s_r.enh_on <= HCC_ENH_RST;
      s_r.link_power_status <= HCC_LPS_RST;
      s_r.pw_on <= HCC_PW_RST;
      s_r.link_en <= HCC_LINK_RST;
      s_r.abt_sup <= HCC_ABT_SUP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Link answer, straight from flops
  assign lnk.ack = s_r.ack;
  assign lnk.abort = s_r.abort;
  assign lnk.rdata = s_r.rdata;

  // PHY-side controls, two cycles behind the register bits
  assign o_data_swap_disable = s_r.stg2[4];
  assign o_enhancement_features_on = s_r.stg2[3];
  assign o_phy_comm_enable = s_r.stg2[2];
  assign o_posted_write_on = s_r.stg2[1];
  assign o_bus_attached = s_r.stg2[0];

  // Flush level and bus reset pulse
  assign o_flush = s_r.flush;
  assign o_bus_reset = s_r.bus_rst;
endmodule

// ==== core/hcc_host_end.sv ====
// Host-side driver for the control bank: software posts one access at a
// time over AXI4-Lite; the driver enforces the programming order.
// Assumes the device answers each request with ack or abort.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module hcc_host_end
  import hcc_pkg::*;
#(
  parameter int SETTLE_CYCLES = HCC_SETTLE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  hcc_link_if.host lnk,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  typedef enum logic [1:0] {H_IDLE, H_REQ, H_SETTLE} hcc_hstate_e;

  typedef struct packed {
    hcc_hstate_e st;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wbuf;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [11:0] cmd_addr;
    logic [31:0] cmd_wdata;
    logic req;
    logic we;
    logic done;
    logic aborted;
    logic refused;
    logic [31:0] ans;
    logic [31:0] shadow;
    logic [CW-1:0] cnt;
    logic bus_rst;
  } hcc_host_s;

  hcc_host_s s_r;
  hcc_host_s s_nxt;

  // Ordering checks on a command before it reaches the device
  function automatic logic cmd_refused(input hcc_host_s s, input logic we_cmd);
    logic is_set;
    logic is_clr;
    is_set = we_cmd && s.cmd_addr == HCC_OFF_SET;
    is_clr = we_cmd && s.cmd_addr == HCC_OFF_CLR;
    cmd_refused = 1'b0;
    if (is_set && s.cmd_wdata[HCC_B_ENH] &&
        !(s.shadow[HCC_B_PERMIT] && s.shadow[HCC_B_LINK])) begin
      cmd_refused = 1'b1;
    end
    if (is_clr && s.cmd_wdata[HCC_B_ENH] && !s.shadow[HCC_B_PERMIT]) begin
      cmd_refused = 1'b1;
    end
    if ((is_set || is_clr) && s.cmd_wdata[HCC_B_PW] && s.shadow[HCC_B_LINK]) begin
      cmd_refused = 1'b1;
    end
  endfunction

  always_comb begin
    logic wr_fire;
    wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    s_nxt = s_r;
    s_nxt.bus_rst = 1'b0;
    // Write channels: address and data caught in either order
    if (s_r.awready && i_awvalid) begin
      s_nxt.awready = 1'b0;
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = i_awaddr;
    end else if (!s_r.aw_got && !s_r.bvalid) begin
      s_nxt.awready = 1'b1;
    end
    if (s_r.wready && i_wvalid) begin
      s_nxt.wready = 1'b0;
      s_nxt.w_got = 1'b1;
      s_nxt.wbuf = i_wdata;
    end else if (!s_r.w_got && !s_r.bvalid) begin
      s_nxt.wready = 1'b1;
    end
    if (s_r.bvalid && i_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // Strobes are ignored: each register is written as a whole word
    if (wr_fire) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      unique case (s_r.awaddr)
        HCC_H_ADDR: s_nxt.cmd_addr = s_r.wbuf[11:0];
        HCC_H_WDATA: s_nxt.cmd_wdata = s_r.wbuf;
        HCC_H_GO: begin
          if (s_r.wbuf[HCC_GO_BUSRST]) begin
            s_nxt.bus_rst = 1'b1;
          end
          if (s_r.wbuf[HCC_GO_START]) begin
            if (s_r.st != H_IDLE || cmd_refused(s_r, s_r.wbuf[HCC_GO_WE])) begin
              s_nxt.refused = 1'b1;
            end else begin
              s_nxt.st = H_REQ;
              s_nxt.req = 1'b1;
              s_nxt.we = s_r.wbuf[HCC_GO_WE];
              s_nxt.done = 1'b0;
              s_nxt.aborted = 1'b0;
              s_nxt.refused = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    // Read channel
    if (s_r.rvalid && i_rready) begin
      s_nxt.rvalid = 1'b0;
    end else if (s_r.arready && i_arvalid) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      unique case (i_araddr)
        HCC_H_ADDR: s_nxt.rdata = {20'h00000, s_r.cmd_addr};
        HCC_H_WDATA: s_nxt.rdata = s_r.cmd_wdata;
        HCC_H_STATUS: s_nxt.rdata = {27'h0000000, s_r.st == H_SETTLE, s_r.refused,
          s_r.aborted, s_r.done, s_r.st != H_IDLE};
        HCC_H_RDATA: s_nxt.rdata = s_r.ans;
        HCC_H_SHADOW: s_nxt.rdata = s_r.shadow;
        default: s_nxt.rdata = '0;
      endcase
    end else if (!s_r.rvalid && !s_r.arready) begin
      s_nxt.arready = 1'b1;
    end
    // Link sequencing
    unique case (s_r.st)
      H_IDLE: ;
      H_REQ: begin
        if (lnk.abort) begin
          s_nxt.req = 1'b0;
          s_nxt.aborted = 1'b1;
          s_nxt.st = H_IDLE;
        end else if (lnk.ack) begin
          s_nxt.req = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.ans = lnk.rdata;
          s_nxt.st = H_IDLE;
          if (s_r.cmd_addr == HCC_OFF_SET || s_r.cmd_addr == HCC_OFF_CLR) begin
            if (!s_r.we) begin
              s_nxt.shadow = lnk.rdata;
            end else if (s_r.cmd_addr == HCC_OFF_SET) begin
              s_nxt.shadow = s_r.shadow | (s_r.cmd_wdata & ~(32'h1 << HCC_B_PERMIT));
              if (s_r.cmd_wdata[HCC_B_LPS]) begin
                s_nxt.cnt = CW'(SETTLE_CYCLES);
                s_nxt.st = H_SETTLE;
              end
              if (s_r.cmd_wdata[HCC_B_LINK]) begin
                s_nxt.bus_rst = 1'b1;
              end
            end else begin
              s_nxt.shadow = s_r.shadow & ~s_r.cmd_wdata;
            end
          end
        end
      end
      H_SETTLE: begin
        s_nxt.cnt = s_r.cnt - CW'(1);
        if (s_r.cnt == CW'(1)) begin
          s_nxt.st = H_IDLE;
        end
      end
      default: s_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.req = s_r.req;
  assign lnk.we = s_r.we;
  assign lnk.addr = s_r.cmd_addr;
  assign lnk.wdata = s_r.cmd_wdata;
  assign lnk.bus_reset_req = s_r.bus_rst;
  assign o_awready = s_r.awready;
  assign o_wready = s_r.wready;
  assign o_bvalid = s_r.bvalid;
  assign o_bresp = 2'h0;
  assign o_arready = s_r.arready;
  assign o_rvalid = s_r.rvalid;
  assign o_rdata = s_r.rdata;
  assign o_rresp = 2'h0;
endmodule

// ==== verif/hcc_asserts.sv ====
// Checker for the register access link between host driver and control bank.
// Assumes one clock; the bench instantiates it beside the link interface.
`timescale 1ns/10ps
module hcc_asserts
  import hcc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic req,
  input wire logic we,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack,
  input wire logic abort,
  input wire logic bus_reset_req,
  input wire logic i_phy_clk_live,
  input wire logic o_bus_reset
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic tk;
  logic in_phy;
  logic sup_r;
  // A request is taken only while no answer is out
  assign tk = req && !ack && !abort;
  assign in_phy = (addr >= HCC_PHY_LO1 && addr <= HCC_PHY_HI1) ||
    (addr >= HCC_PHY_LO2 && addr <= HCC_PHY_HI2);
  // Mirror of abort suppress; stopped-clock writes are ignored, so only live ones count
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sup_r <= 1'b0;
    end else if (tk && we && i_phy_clk_live && addr == HCC_OFF_MISC) begin
      sup_r <= wdata[HCC_B_ABT_SUP];
    end
  end
  property p_answer;
    tk |=> (ack != abort);
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  property p_pulse;
    (ack || abort) |=> !ack && !abort;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_cause;
    (ack || abort) |-> $past(req);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_abort;
    tk && !i_phy_clk_live && in_phy && !sup_r |=> abort;
  endproperty
  a_abort: assert property (p_abort) else $error("stopped clock access not aborted");
  property p_ones;
    tk && !we && !i_phy_clk_live && in_phy && sup_r |=> ack && rdata == 32'hffff_ffff;
  endproperty
  a_ones: assert property (p_ones) else $error("suppressed access not all ones");
  property p_live;
    tk && i_phy_clk_live && in_phy |=> ack;
  endproperty
  a_live: assert property (p_live) else $error("live clock access not acked");
  property p_rsvd;
    ack && !we && (addr == HCC_OFF_SET || addr == HCC_OFF_CLR) |-> (rdata & 32'hbf30_ffff) == 0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved control bit reads one");
  property p_hold;
    !ack |-> $stable(rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("answer data moved without ack");
  property p_brst;
    o_bus_reset |-> $past(bus_reset_req);
  endproperty
  a_brst: assert property (p_brst) else $error("bus reset without request");
endmodule

// ==== verif/tb_top.sv ====
// Bench for both ends: AXI4-Lite commands into the host driver, which talks
// to the control bank over the link. Assumes a 20 MHz clock, sync reset.
`timescale 1ns/10ps
module tb_top;
  import hcc_pkg::*;
  logic i_sys_clk, i_rst, live, rom_load, rom_permit;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic swap_dis, enh_on, phy_comm, pw_on, attached, flush, bus_rst;
  logic [4:0] st;
  logic [11:0] inr [4] = '{12'h0dc, 12'h0f0, 12'h100, 12'h11c};
  logic [11:0] outr [4] = '{12'h0d8, 12'h0f4, 12'h0fc, 12'h120};
  int fails = 0, cmp_count = 0, brst_cnt = 0, flush_cnt = 0, n0;
  hcc_link_if lnk();
  hcc_device_end #(.SR_CYCLES(HCC_SR_CYCLES)) hcc_device_end_inst (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .lnk(lnk), .i_phy_clk_live(live), .i_rom_load(rom_load),
    .i_rom_permit(rom_permit), .o_data_swap_disable(swap_dis),
    .o_enhancement_features_on(enh_on), .o_phy_comm_enable(phy_comm),
    .o_posted_write_on(pw_on), .o_bus_attached(attached), .o_flush(flush), .o_bus_reset(bus_rst));
  // Short settle count keeps the run brief
  hcc_host_end #(.SETTLE_CYCLES(20)) hcc_host_end_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .lnk(lnk), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
  hcc_asserts hcc_asserts_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .req(lnk.req),
    .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack),
    .abort(lnk.abort), .bus_reset_req(lnk.bus_reset_req), .i_phy_clk_live(live),
    .o_bus_reset(bus_rst));
  // Free-running system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // Pulse counters; pulses are too short to catch by polling over AXI
  always @(posedge i_sys_clk) begin
    if (bus_rst === 1'b1) brst_cnt++;
    if (flush === 1'b1) flush_cnt++;
  end
  task end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task limit_out();
    fails++;
    $display("wait limit reached at %0t", $time);
    end_sim();
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    bready <= 1'b0;
    if (n >= 200) limit_out();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    d = rdata;
    rready <= 1'b0;
    if (n >= 200) limit_out();
  endtask
  // One link access; status returns {settling seen, refused, aborted, done, busy}
  task automatic cmd(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [4:0] s, output logic [31:0] r);
    logic [31:0] v;
    logic seen;
    int n;
    seen = 1'b0;
    n = 0;
    axi_wr(HCC_H_ADDR, {20'h0, a});
    axi_wr(HCC_H_WDATA, d);
    axi_wr(HCC_H_GO, {30'h0, 1'b1, w});
    do begin
      axi_rd(HCC_H_STATUS, v);
      seen = seen | v[4];
      n++;
    end while (v[0] !== 1'b0 && n < 100);
    if (n >= 100) limit_out();
    axi_rd(HCC_H_RDATA, r);
    s = {seen, v[3:0]};
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    cmd(1'b0, a, 32'h0, st, rd);
    chk(e, rd);
  endtask
  task brst(input int e);
    n0 = brst_cnt;
    axi_wr(HCC_H_GO, 32'h4);
    repeat (6) @(posedge i_sys_clk);
    chk(e, brst_cnt - n0);
  endtask
  initial begin
    i_rst = 1'b1; live = 1'b1; rom_load = 1'b0; rom_permit = 1'b0; wstrb = 4'hf;
    awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rdc(HCC_OFF_SET, 32'h0);
    rdc(HCC_OFF_CLR, 32'h0);
    $display("test reset values done");
    n0 = brst_cnt;
    cmd(1'b1, HCC_OFF_SET, 32'h400e_0000, st, rd);
    chk(32'h1, {31'h0, st[4]});
    chk(32'h1, brst_cnt - n0);
    cmd(1'b1, HCC_OFF_SET, 32'hbf30_ffff, st, rd);
    rdc(HCC_OFF_SET, 32'h400e_0000);
    rdc(HCC_OFF_CLR, 32'h400e_0000);
    chk(32'hf, {28'h0, swap_dis, phy_comm, pw_on, attached});
    brst(1);
    $display("test set view done");
    cmd(1'b1, HCC_OFF_SET, 32'h0004_0000, st, rd);
    chk(32'h2, {30'h0, st[3:2]});
    cmd(1'b1, HCC_OFF_SET, 32'h0040_0000, st, rd);
    chk(32'h2, {30'h0, st[3:2]});
    cmd(1'b1, HCC_OFF_CLR, 32'h0040_0000, st, rd);
    chk(32'h2, {30'h0, st[3:2]});
    $display("test refusals done");
    @(posedge i_sys_clk);
    rom_permit <= 1'b1;
    rom_load <= 1'b1;
    @(posedge i_sys_clk);
    rom_load <= 1'b0;
    rdc(HCC_OFF_SET, 32'h408e_0000);
    cmd(1'b1, HCC_OFF_SET, 32'h0040_0000, st, rd);
    rdc(HCC_OFF_SET, 32'h40ce_0000);
    chk(32'h1, {31'h0, enh_on});
    cmd(1'b1, HCC_OFF_CLR, 32'h00c0_0000, st, rd);
    cmd(1'b1, HCC_OFF_SET, 32'h0080_0000, st, rd);
    rdc(HCC_OFF_SET, 32'h400e_0000);
    $display("test permit done");
    cmd(1'b1, HCC_OFF_CLR, 32'h0002_0000, st, rd);
    rdc(HCC_OFF_CLR, 32'h400c_0000);
    chk(32'h0, {31'h0, attached});
    brst(0);
    cmd(1'b1, HCC_OFF_CLR, 32'h4004_0000, st, rd);
    rdc(HCC_OFF_SET, 32'h0008_0000);
    $display("test clear view done");
    live <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      cmd(1'b0, inr[i], 32'h0, st, rd);
      chk(32'h1, {31'h0, st[2]});
      cmd(1'b0, outr[i], 32'h0, st, rd);
      chk(32'h0, {31'h0, st[2]});
    end
    live <= 1'b1;
    cmd(1'b1, HCC_OFF_MISC, 32'h10, st, rd);
    live <= 1'b0;
    cmd(1'b1, HCC_OFF_MISC, 32'h0, st, rd);
    for (int i = 0; i < 4; i++) begin
      cmd(1'b0, inr[i], 32'h0, st, rd);
      chk(32'hffff_ffff, rd);
      chk(32'h0, {31'h0, st[2]});
    end
    $display("test stopped clock done");
    live <= 1'b1;
    cmd(1'b1, HCC_OFF_SET, 32'h4002_0000, st, rd);
    n0 = flush_cnt;
    cmd(1'b1, HCC_OFF_SET, 32'h0001_0000, st, rd);
    repeat (20) @(posedge i_sys_clk);
    chk(HCC_SR_CYCLES, flush_cnt - n0);
    rdc(HCC_OFF_SET, 32'h0);
    chk(32'h0, {29'h0, attached, phy_comm, swap_dis});
    live <= 1'b0;
    rdc(12'h100, 32'hffff_ffff);
    $display("test self reset done");
    end_sim();
  end
endmodule
